// File: rbip_defines.vh
// Register offsets, field positions, reset values and timing counts for the reset/boot/irq block
`ifndef RBIP_DEFINES_VH
`define RBIP_DEFINES_VH

`define RBIP_ADDR_W          4
`define RBIP_OFF_CTRL        4'h0
`define RBIP_OFF_STATUS      4'h1
`define RBIP_OFF_IRQ_STAT    4'h2
`define RBIP_OFF_IRQ_CLR     4'h3
`define RBIP_OFF_IRQ_EN      4'h4
`define RBIP_OFF_PUDR        4'h5
`define RBIP_OFF_PORTE_PUR   4'h6
`define RBIP_OFF_POWER       4'h7

// Control register fields
`define RBIP_CTRL_A_EDGE     0
`define RBIP_CTRL_B_EDGE     1
`define RBIP_CTRL_RST        8'h00

// Status register fields
`define RBIP_ST_MODE_A       0
`define RBIP_ST_MODE_B       1
`define RBIP_ST_WIDE_EMI     2
`define RBIP_ST_IRQ_A        3
`define RBIP_ST_IRQ_B        4

// Pull-up disable register fields, set bit turns pull-up off
`define RBIP_PUDR_IRQ        0
`define RBIP_PUDR_RESET      1
`define RBIP_PUDR_BOOT       2
`define RBIP_PUDR_EMI        3
`define RBIP_PUDR_RST        8'h00

// Port E pull-up register, set bit enables pull-up
`define RBIP_PORTE_PUR_RST   16'hFFFF

// Power mode register: 0 run, 1 wait, 2 stop
`define RBIP_PWR_RUN         2'h0
`define RBIP_PWR_WAIT        2'h1
`define RBIP_PWR_STOP        2'h2

// Interrupt status events
`define RBIP_EV_IRQ_A        0
`define RBIP_EV_IRQ_B        1
`define RBIP_EV_RST_DONE     2
`define RBIP_EV_W            3

// Reset stretch count in internal clocks
`define RBIP_RST_STRETCH     16

`endif

// File: rbip_irq_detect.v
// One external interrupt line: level or falling edge, synchronised or asynchronous capture
`timescale 1ns/1ps
`include "rbip_defines.vh"

module rbip_irq_detect (
    // Clock and reset
    input  wire i_clk,
    input  wire i_arst_n,
    // Pin and configuration
    input  wire i_irq_n,
    input  wire i_edge_mode,
    input  wire i_low_power,
    input  wire i_ack,
    // Request
    output reg  o_req
);

    reg  sync1_r;
    reg  sync2_r;
    reg  prev_r;
    reg  async_hit_r;
    wire async_clr;
    wire pin_low;
    wire fall;

    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            sync1_r <= 1'b1;
            sync2_r <= 1'b1;
            prev_r  <= 1'b1;
        end else begin
            sync1_r <= i_irq_n;
            sync2_r <= sync1_r;
            prev_r  <= sync2_r;
        end
    end

    // Clockless capture: pin falling edge in wait or stop sets, cleared once consumed
    assign async_clr = ~i_arst_n | (o_req & ~i_low_power);
    always @(negedge i_irq_n or posedge async_clr) begin
        if (async_clr) begin
            async_hit_r <= 1'b0;
        end else if (i_low_power) begin
            async_hit_r <= 1'b1;
        end
    end

    assign pin_low = ~sync2_r;
    assign fall    = prev_r & ~sync2_r;

    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_req <= 1'b0;
        end else if (i_edge_mode) begin
            if (fall || async_hit_r) begin
                o_req <= 1'b1;
            end else if (i_ack) begin
                o_req <= 1'b0;
            end
        end else begin
            o_req <= pin_low | async_hit_r;
        end
    end

endmodule

// File: rbip_top.v
// Reset sequencer, boot strap latch, interrupt pins and pull-up control
`timescale 1ns/1ps
`include "rbip_defines.vh"

module rbip_top #(
    parameter RST_STRETCH = `RBIP_RST_STRETCH,
    parameter PORTE_W     = 16
) (
    // Clock and power-on reset
    input  wire                     i_clk,
    input  wire                     i_arst_n,
    // Pins
    input  wire                     i_reset_pin_n,
    input  wire                     i_ext_irq_a_n,
    input  wire                     i_ext_irq_b_n,
    input  wire                     i_boot_select_strap,
    input  wire                     i_ext_mem_width_strap,
    input  wire                     i_flash_secured,
    // Avalon-MM slave
    input  wire [`RBIP_ADDR_W-1:0]  i_avs_address,
    input  wire                     i_avs_read,
    input  wire                     i_avs_write,
    input  wire [31:0]              i_avs_writedata,
    output reg  [31:0]              o_avs_readdata,
    output reg                      o_avs_waitrequest,
    // Reset and mode
    output reg                      o_int_reset,
    output reg                      o_reset_status_out,
    output reg                      o_boot_external,
    output reg                      o_ext_mem_wide,
    // Interrupts
    output reg                      o_ext_irq_a_req,
    output reg                      o_ext_irq_b_req,
    output reg                      o_irq,
    // Pull-up enables, high means pull-up on
    output reg                      o_irq_pullup_en,
    output reg                      o_reset_pullup_en,
    output reg                      o_boot_strap_pullup_en,
    output reg                      o_ext_mem_width_pullup_en,
    output reg  [PORTE_W-1:0]       o_port_e_pullup_en
);

    localparam CNT_W = 16;
    localparam [CNT_W-1:0] STRETCH = RST_STRETCH;

    localparam [1:0] ST_HOLD    = 2'h0;
    localparam [1:0] ST_STRETCH = 2'h1;
    localparam [1:0] ST_RUN     = 2'h2;

    reg  [1:0]               state_r;
    reg  [1:0]               state_nxt;
    reg  [CNT_W-1:0]         cnt_r;
    reg  [CNT_W-1:0]         cnt_nxt;
    reg  [1:0]               rpin_sync_r;
    reg                      por_r;
    reg  [7:0]               ctrl_r;
    reg  [7:0]               pullup_disable_reg_r;
    reg  [PORTE_W-1:0]       port_e_pullup_reg_r;
    reg  [1:0]               power_r;
    reg  [`RBIP_EV_W-1:0]    irq_stat_r;
    reg  [`RBIP_EV_W-1:0]    irq_en_r;
    reg  [`RBIP_EV_W-1:0]    ev;
    reg                      rst_active_r;
    reg                      pend_r;
    reg                      boot_sel_r;
    reg                      secured_r;
    reg  [31:0]              rdata;
    wire                     req_a;
    wire                     req_b;
    wire                     low_power;
    wire                     pin_low;
    wire                     wr_acc;
    wire                     rd_acc;

    assign low_power = (power_r == `RBIP_PWR_WAIT) || (power_r == `RBIP_PWR_STOP);

    // Pin reset is sampled through two flops
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rpin_sync_r <= 2'b00;
            por_r       <= 1'b1;
        end else begin
            rpin_sync_r <= {rpin_sync_r[0], i_reset_pin_n};
            por_r       <= 1'b0;
        end
    end
    assign pin_low = ~rpin_sync_r[1];

    // Reset sequencer
    always @* begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        case (state_r)
            ST_HOLD: begin
                cnt_nxt = {CNT_W{1'b0}};
                if (!pin_low && !por_r) begin
                    state_nxt = ST_STRETCH;
                end
            end
            ST_STRETCH: begin
                if (pin_low) begin
                    state_nxt = ST_HOLD;
                end else if (cnt_r == STRETCH - 1'b1) begin
                    state_nxt = ST_RUN;
                end else begin
                    cnt_nxt = cnt_r + 1'b1;
                end
            end
            ST_RUN: begin
                if (pin_low) begin
                    state_nxt = ST_HOLD;
                end
            end
            default: begin
                state_nxt = ST_HOLD;
            end
        endcase
    end

    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state_r            <= ST_HOLD;
            cnt_r              <= {CNT_W{1'b0}};
            rst_active_r       <= 1'b1;
            o_int_reset        <= 1'b1;
            o_reset_status_out <= 1'b1;
        end else begin
            state_r            <= state_nxt;
            cnt_r              <= cnt_nxt;
            rst_active_r       <= (state_nxt != ST_RUN);
            o_int_reset        <= (state_nxt != ST_RUN);
            o_reset_status_out <= (state_nxt != ST_RUN);
        end
    end

    // Straps caught at pin release, mode resolved from flash security
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            boot_sel_r      <= 1'b0;
            secured_r       <= 1'b1;
            o_boot_external <= 1'b0;
            o_ext_mem_wide  <= 1'b0;
        end else if (state_r == ST_HOLD && state_nxt == ST_STRETCH) begin
            boot_sel_r      <= i_boot_select_strap;
            secured_r       <= i_flash_secured;
            o_boot_external <= i_boot_select_strap & ~i_flash_secured;
            o_ext_mem_wide  <= i_boot_select_strap & ~i_flash_secured
                               & i_ext_mem_width_strap;
        end
    end

    // Interrupt line detectors
    rbip_irq_detect u_irq_a (
        .i_clk       (i_clk),
        .i_arst_n    (i_arst_n),
        .i_irq_n     (i_ext_irq_a_n),
        .i_edge_mode (ctrl_r[`RBIP_CTRL_A_EDGE]),
        .i_low_power (low_power),
        .i_ack       (irq_stat_r[`RBIP_EV_IRQ_A] == 1'b0 && o_ext_irq_a_req),
        .o_req       (req_a)
    );

    rbip_irq_detect u_irq_b (
        .i_clk       (i_clk),
        .i_arst_n    (i_arst_n),
        .i_irq_n     (i_ext_irq_b_n),
        .i_edge_mode (ctrl_r[`RBIP_CTRL_B_EDGE]),
        .i_low_power (low_power),
        .i_ack       (irq_stat_r[`RBIP_EV_IRQ_B] == 1'b0 && o_ext_irq_b_req),
        .o_req       (req_b)
    );

    // Events: request rising edges and reset sequence done
    always @* begin
        ev = {`RBIP_EV_W{1'b0}};
        ev[`RBIP_EV_IRQ_A]    = req_a & ~o_ext_irq_a_req;
        ev[`RBIP_EV_IRQ_B]    = req_b & ~o_ext_irq_b_req;
        ev[`RBIP_EV_RST_DONE] = rst_active_r & (state_nxt == ST_RUN);
    end

    // Bus slave: one wait cycle, answer on second cycle
    // Read data loads as waitrequest drops, so it stands at the accepting edge
    assign wr_acc = i_avs_write & pend_r;
    assign rd_acc = i_avs_read & ~pend_r;

    always @* begin
        rdata = 32'h0000_0000;
        case (i_avs_address)
            `RBIP_OFF_CTRL:      rdata[7:0] = ctrl_r;
            `RBIP_OFF_STATUS: begin
                rdata[`RBIP_ST_MODE_A]   = boot_sel_r & ~secured_r;
                rdata[`RBIP_ST_MODE_B]   = ~secured_r;
                rdata[`RBIP_ST_WIDE_EMI] = o_ext_mem_wide;
                rdata[`RBIP_ST_IRQ_A]    = o_ext_irq_a_req;
                rdata[`RBIP_ST_IRQ_B]    = o_ext_irq_b_req;
            end
            `RBIP_OFF_IRQ_STAT:  rdata[`RBIP_EV_W-1:0] = irq_stat_r;
            `RBIP_OFF_IRQ_EN:    rdata[`RBIP_EV_W-1:0] = irq_en_r;
            `RBIP_OFF_PUDR:      rdata[7:0] = pullup_disable_reg_r;
            `RBIP_OFF_PORTE_PUR: rdata[PORTE_W-1:0] = port_e_pullup_reg_r;
            `RBIP_OFF_POWER:     rdata[1:0] = power_r;
            default:             rdata = 32'h0000_0000;
        endcase
    end

    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            pend_r               <= 1'b0;
            o_avs_waitrequest    <= 1'b1;
            o_avs_readdata       <= 32'h0000_0000;
            ctrl_r               <= `RBIP_CTRL_RST;
            pullup_disable_reg_r <= `RBIP_PUDR_RST;
            port_e_pullup_reg_r  <= `RBIP_PORTE_PUR_RST;
            power_r              <= `RBIP_PWR_RUN;
            irq_en_r             <= {`RBIP_EV_W{1'b0}};
            irq_stat_r           <= {`RBIP_EV_W{1'b0}};
        end else begin
            pend_r            <= (i_avs_read | i_avs_write) & ~pend_r;
            o_avs_waitrequest <= ~((i_avs_read | i_avs_write) & ~pend_r);
            if (rd_acc) begin
                o_avs_readdata <= rdata;
            end
            if (wr_acc) begin
                case (i_avs_address)
                    `RBIP_OFF_CTRL:      ctrl_r <= i_avs_writedata[7:0];
                    `RBIP_OFF_IRQ_EN:    irq_en_r <= i_avs_writedata[`RBIP_EV_W-1:0];
                    `RBIP_OFF_PUDR:      pullup_disable_reg_r <= i_avs_writedata[7:0];
                    `RBIP_OFF_PORTE_PUR: port_e_pullup_reg_r <= i_avs_writedata[PORTE_W-1:0];
                    `RBIP_OFF_POWER:     power_r <= i_avs_writedata[1:0];
                    default:             power_r <= power_r;
                endcase
            end
            // Set wins over write-one-to-clear
            if (wr_acc && i_avs_address == `RBIP_OFF_IRQ_CLR) begin
                irq_stat_r <= (irq_stat_r & ~i_avs_writedata[`RBIP_EV_W-1:0]) | ev;
            end else begin
                irq_stat_r <= irq_stat_r | ev;
            end
        end
    end

    // Registered outputs
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_ext_irq_a_req           <= 1'b0;
            o_ext_irq_b_req           <= 1'b0;
            o_irq                     <= 1'b0;
            o_irq_pullup_en           <= 1'b1;
            o_reset_pullup_en         <= 1'b1;
            o_boot_strap_pullup_en    <= 1'b1;
            o_ext_mem_width_pullup_en <= 1'b1;
            o_port_e_pullup_en        <= `RBIP_PORTE_PUR_RST;
        end else begin
            o_ext_irq_a_req           <= req_a;
            o_ext_irq_b_req           <= req_b;
            o_irq                     <= |((irq_stat_r | ev) & irq_en_r);
            o_irq_pullup_en           <= ~pullup_disable_reg_r[`RBIP_PUDR_IRQ];
            o_reset_pullup_en         <= ~pullup_disable_reg_r[`RBIP_PUDR_RESET];
            o_boot_strap_pullup_en    <= ~pullup_disable_reg_r[`RBIP_PUDR_BOOT];
            o_ext_mem_width_pullup_en <= ~pullup_disable_reg_r[`RBIP_PUDR_EMI];
            o_port_e_pullup_en        <= port_e_pullup_reg_r;
        end
    end

endmodule

// File: rbip_checker.sv
// Concurrent checks on the reset, boot strap, interrupt and pull-up ports
`timescale 1ns/1ps
module rbip_checker #(
    parameter RST_STRETCH = 16,
    parameter PORTE_W     = 16
) (
    // Clock, reset and pins
    input logic               i_clk,
    input logic               i_arst_n,
    input logic               i_reset_pin_n,
    input logic               i_ext_irq_a_n,
    input logic               i_boot_select_strap,
    input logic               i_ext_mem_width_strap,
    input logic               i_flash_secured,
    // Bus
    input logic [3:0]         i_avs_address,
    input logic               i_avs_write,
    input logic [31:0]        i_avs_writedata,
    input logic               o_avs_waitrequest,
    // Outputs watched
    input logic               o_int_reset,
    input logic               o_reset_status_out,
    input logic               o_boot_external,
    input logic               o_ext_mem_wide,
    input logic               o_ext_irq_a_req,
    input logic               o_irq_pullup_en,
    input logic               o_reset_pullup_en,
    input logic               o_boot_strap_pullup_en,
    input logic               o_ext_mem_width_pullup_en,
    input logic [PORTE_W-1:0] o_port_e_pullup_en
);
    logic [7:0] hi_cnt_r;
    logic       edge_a_r;
    logic [1:0] pwr_r;
    wire        wr_ok = i_avs_write && !o_avs_waitrequest;
    // Pin-high age and shadow of edge and power settings
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            hi_cnt_r <= 8'h00;
            edge_a_r <= 1'b0;
            pwr_r <= 2'h0;
        end else begin
            hi_cnt_r <= !i_reset_pin_n ? 8'h00 : hi_cnt_r + {7'h00, hi_cnt_r != 8'hFF};
            if (wr_ok && i_avs_address == 4'h0) edge_a_r <= i_avs_writedata[0];
            if (wr_ok && i_avs_address == 4'h7) pwr_r <= i_avs_writedata[1:0];
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);
    sequence s_rel;
        $fell(o_int_reset);
    endsequence
    sequence s_run_a;
        pwr_r == 2'h0 && !edge_a_r && $stable(i_ext_irq_a_n);
    endsequence
    AST_STATUS_MIRROR: assert property (o_reset_status_out == o_int_reset)
        else $error("reset status output differs from internal reset");
    AST_POR_HOLD: assert property ($rose(i_arst_n) |-> o_int_reset)
        else $error("internal reset not active after power-on");
    AST_PIN_HOLD: assert property (!i_reset_pin_n [*4] |-> o_int_reset)
        else $error("internal reset inactive while pin held low");
    AST_STRETCH: assert property (s_rel |-> hi_cnt_r >= RST_STRETCH && hi_cnt_r <= RST_STRETCH + 6)
        else $error("internal reset released after wrong count");
    AST_BOOT_MODE: assert property (s_rel |-> o_boot_external == (i_boot_select_strap && !i_flash_secured))
        else $error("boot choice wrong at reset release");
    AST_WIDE_BUS: assert property (s_rel |-> o_ext_mem_wide == (i_boot_select_strap && !i_flash_secured && i_ext_mem_width_strap))
        else $error("memory width wrong at reset release");
    AST_MODE_KEEP: assert property (!o_int_reset && !$past(o_int_reset) |-> $stable(o_boot_external) && $stable(o_ext_mem_wide))
        else $error("boot mode changed outside reset");
    AST_LEVEL_A: assert property (s_run_a [*4] |-> o_ext_irq_a_req == !i_ext_irq_a_n)
        else $error("level request does not follow pin");
    AST_SYNC_A: assert property (pwr_r == 2'h0 && $fell(i_ext_irq_a_n) && !o_ext_irq_a_req |=> !o_ext_irq_a_req [*3])
        else $error("request bypassed the synchroniser");
    AST_PUD: assert property (wr_ok && i_avs_address == 4'h5 |-> ##2 {o_ext_mem_width_pullup_en, o_boot_strap_pullup_en, o_reset_pullup_en, o_irq_pullup_en} == ~$past(i_avs_writedata[3:0], 2))
        else $error("pull-up disable bits not applied");
    AST_PORTE: assert property (wr_ok && i_avs_address == 4'h6 |-> ##2 o_port_e_pullup_en == $past(i_avs_writedata[PORTE_W-1:0], 2))
        else $error("port E pull-up bits not applied");
endmodule
bind rbip_top rbip_checker #(.RST_STRETCH(RST_STRETCH), .PORTE_W(PORTE_W)) u_chk (.*);

// File: rbip_board.sv
// Board model: reset supervisor, interrupt sources and strap resistors
`timescale 1ns/1ps
module rbip_board (
    // Clock
    input  logic i_clk,
    // Pins toward the device
    output logic o_reset_pin_n,
    output logic o_test_rst_n,
    output logic o_irq_a_n,
    output logic o_irq_b_n,
    output logic o_boot,
    output logic o_mem,
    output logic o_sec
);
    initial begin
        {o_reset_pin_n, o_test_rst_n, o_irq_a_n, o_irq_b_n} = 4'hF;
        {o_boot, o_mem, o_sec} = 3'h0;
    end
    // Reset pulse; straps settle with the pin low and stay put
    task automatic hard_reset(input logic boot, mem, sec, full);
        @(posedge i_clk);
        o_boot <= boot;
        o_mem <= mem;
        o_sec <= sec;
        o_reset_pin_n <= 1'b0;
        o_test_rst_n <= !full;
        repeat (6) @(posedge i_clk);
        o_reset_pin_n <= 1'b1;
        o_test_rst_n <= 1'b1;
    endtask
    // Open-collector sources with board pull-ups
    task automatic irq(input logic a_low, b_low);
        o_irq_a_n <= !a_low;
        o_irq_b_n <= !b_low;
    endtask
endmodule

// File: test_reset_boot_irq_pins.sv
// Self-checking bench for the reset, boot strap, interrupt and pull-up block
`timescale 1ns/1ps
module test_reset_boot_irq_pins;
    localparam int RS = 4;
    logic        i_clk, i_arst_n, clk_on, i_avs_read, i_avs_write;
    logic [3:0]  i_avs_address;
    logic [31:0] i_avs_writedata, q;
    wire         pin_n, irq_a_n, irq_b_n, boot, mem, sec, waitreq, int_rst, rst_out;
    wire         boot_ext, wide, req_a, req_b, irq, pu_irq, pu_rst, pu_boot, pu_mem;
    wire  [31:0] rdata;
    wire  [15:0] pu_e;
    int          n_fail, n_checks;
    rbip_board BRD (.i_clk(i_clk), .o_reset_pin_n(pin_n), .o_test_rst_n(), .o_irq_a_n(irq_a_n),
        .o_irq_b_n(irq_b_n), .o_boot(boot), .o_mem(mem), .o_sec(sec));
    rbip_top #(.RST_STRETCH(RS), .PORTE_W(16)) DUT (.i_clk(i_clk), .i_arst_n(i_arst_n),
        .i_reset_pin_n(pin_n), .i_ext_irq_a_n(irq_a_n), .i_ext_irq_b_n(irq_b_n),
        .i_boot_select_strap(boot), .i_ext_mem_width_strap(mem), .i_flash_secured(sec),
        .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
        .i_avs_writedata(i_avs_writedata), .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq),
        .o_int_reset(int_rst), .o_reset_status_out(rst_out), .o_boot_external(boot_ext),
        .o_ext_mem_wide(wide), .o_ext_irq_a_req(req_a), .o_ext_irq_b_req(req_b), .o_irq(irq),
        .o_irq_pullup_en(pu_irq), .o_reset_pullup_en(pu_rst), .o_boot_strap_pullup_en(pu_boot),
        .o_ext_mem_width_pullup_en(pu_mem), .o_port_e_pullup_en(pu_e));
    initial begin
        i_clk = 1'b0;
        forever #20 if (clk_on) i_clk = ~i_clk;
    end
    task automatic chk(input string nm, input logic [31:0] exp, got);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge i_clk);
        i_avs_address <= a;
        i_avs_writedata <= d;
        i_avs_write <= wr;
        i_avs_read <= !wr;
        do begin
            @(posedge i_clk);
            n++;
        end while (waitreq !== 1'b0 && n < 50);
        q = rdata;
        if (n >= 50) n_fail++;
        i_avs_write <= 1'b0;
        i_avs_read <= 1'b0;
    endtask
    task automatic rd_chk(input string nm, input logic [3:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(nm, e, q);
    endtask
    task automatic wait_rel(output int n);
        n = 0;
        while (int_rst !== 1'b0 && n < 100) begin
            @(posedge i_clk);
            n++;
        end
        if (n >= 100) n_fail++;
    endtask
    task automatic t_por;
        int n;
        chk("status out", 32'h1, rst_out);
        wait_rel(n);
        chk("stretch", 32'h1, n >= RS && n <= RS + 6);
        chk("status out off", 32'h0, rst_out);
        $display("done power-on");
    endtask
    task automatic t_boot;
        int n;
        logic [2:0] k;
        for (int i = 0; i < 9; i++) begin
            k = i[2:0];
            BRD.hard_reset(k[0], k[2], k[1], k[0]);
            chk("held", 32'h1, int_rst);
            wait_rel(n);
            chk("boot ext", k[0] & !k[1], boot_ext);
            chk("wide", k[0] & !k[1] & k[2], wide);
            rd_chk("mode", 4'h1, {29'h0, k[0] & !k[1] & k[2], !k[1], k[0] & !k[1]});
        end
        $display("done boot straps");
    endtask
    task automatic t_lvl;
        bus(1'b1, 4'h0, 32'h0);
        bus(1'b1, 4'h4, 32'h3);
        bus(1'b1, 4'h3, 32'h7);
        BRD.irq(1'b1, 1'b0);
        repeat (6) @(posedge i_clk);
        chk("req a", 32'h1, req_a);
        chk("irq", 32'h1, irq);
        rd_chk("irq stat", 4'h2, 32'h1);
        BRD.irq(1'b0, 1'b0);
        repeat (6) @(posedge i_clk);
        chk("req a off", 32'h0, req_a);
        bus(1'b1, 4'h4, 32'h2);
        repeat (2) @(posedge i_clk);
        chk("masked", 32'h0, irq);
        bus(1'b1, 4'h3, 32'h1);
        rd_chk("irq clr", 4'h2, 32'h0);
        $display("done level irq");
    endtask
    task automatic t_edge;
        bus(1'b1, 4'h0, 32'h2);
        BRD.irq(1'b0, 1'b1);
        repeat (3) @(posedge i_clk);
        BRD.irq(1'b0, 1'b0);
        repeat (6) @(posedge i_clk);
        chk("req b held", 32'h1, req_b);
        chk("req a idle", 32'h0, req_a);
        bus(1'b1, 4'h3, 32'h2);
        repeat (3) @(posedge i_clk);
        chk("req b clr", 32'h0, req_b);
        $display("done edge irq");
    endtask
    task automatic t_stop;
        bus(1'b1, 4'h0, 32'h1);
        bus(1'b1, 4'h7, 32'h2);
        @(posedge i_clk);
        clk_on = 1'b0;
        #200 BRD.irq(1'b1, 1'b0);
        #100 BRD.irq(1'b0, 1'b0);
        #100 clk_on = 1'b1;
        repeat (6) @(posedge i_clk);
        chk("stop capture", 32'h1, req_a);
        bus(1'b1, 4'h7, 32'h0);
        bus(1'b1, 4'h3, 32'h1);
        bus(1'b1, 4'h0, 32'h0);
        $display("done stop irq");
    endtask
    task automatic t_pull;
        rd_chk("pudr rst", 4'h5, 32'h0);
        rd_chk("porte rst", 4'h6, 32'hFFFF);
        bus(1'b1, 4'h5, 32'hF);
        repeat (2) @(posedge i_clk);
        chk("pull off", 32'h0, {pu_mem, pu_boot, pu_rst, pu_irq});
        bus(1'b1, 4'h5, 32'h5);
        repeat (2) @(posedge i_clk);
        chk("pull mix", 32'hA, {pu_mem, pu_boot, pu_rst, pu_irq});
        bus(1'b1, 4'h6, 32'h00FE);
        repeat (2) @(posedge i_clk);
        chk("port e", 32'h00FE, pu_e);
        bus(1'b1, 4'hF, 32'hFF);
        rd_chk("unmapped", 4'hF, 32'h0);
        bus(1'b1, 4'h1, 32'hFF);
        rd_chk("status ro", 4'h1, 32'h2);
        $display("done pull-ups");
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        {i_arst_n, i_avs_read, i_avs_write, i_avs_address, i_avs_writedata} = 39'h0;
        {clk_on, n_fail, n_checks} = 0;
        clk_on = 1'b1;
        repeat (4) @(posedge i_clk);
        i_arst_n <= 1'b1;
        @(posedge i_clk);
        t_por;
        t_boot;
        t_lvl;
        t_edge;
        t_stop;
        t_pull;
        end_sim;
    end
    initial begin
        #1000000;
        n_fail++;
        end_sim;
    end
endmodule
